// ---- hw/bft_bit_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module bft_bit_test #(
   parameter int W = 16
) (
   input  wire logic [W-1:0] i_mask,
   input  wire logic [W-1:0] i_data,
   input  wire logic         i_ones_mode,
   output logic              o_all_match
);
   logic [W-1:0] miss;

   // Each selected bit that disagrees with the wanted level is a miss
   genvar i;
   generate
      for (i = 0; i < W; i++)
      begin : g_bit
         assign miss[i] = i_mask[i] & (i_ones_mode ? ~i_data[i] : i_data[i]);
      end
   endgenerate

   // An empty mask has no misses, so the result is set
   assign o_all_match = ~|miss;
endmodule
`default_nettype wire

// ---- hw/bft_core.sv ----
// The implementer's own choices: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Ones test sets carry iff selected bits one
// - Zeros test sets carry iff selected bits zero
// - Sixteen-bit mask, ones select tested bits
// - Each test reads its destination twice
// - Empty mask sets carry, destination untouched
// - Limiting on 36-bit source move sets limit flag
// - Test timing 4/2, 6/2 indexed, 6/3 long
// - Register form rejects the hardware stack register
// - Short direct address is six-bit absolute
// - I/O short address is six bits within the I/O page
// - Branch target is next address plus displacement
// - Displacement is signed seven bits, sign extended
// - Branch leaves all condition flags unchanged
// - Branch takes six cycles plus waits, one word
module bft_core #(
   parameter int          MEM_AW      = 8,
   parameter logic [3:0]  WAIT_STATES = 4'h0
) (
   input  wire logic        i_clk,
   input  wire logic        i_sys_rst,
   input  wire logic [7:0]  i_avs_address,
   input  wire logic        i_avs_read,
   input  wire logic        i_avs_write,
   input  wire logic [31:0] i_avs_writedata,
   output logic [31:0]      o_avs_readdata,
   output logic             o_avs_waitrequest,
   output logic             o_busy,
   output logic [15:0]      o_pc,
   output logic [15:0]      o_status_word
);
   typedef enum logic [2:0] {ST_IDLE, ST_ACC1, ST_ACC2, ST_EVAL, ST_WAIT} bft_state_e;

   bft_mem_if #(.AW(MEM_AW), .DW(16)) mem_bus ();

   bft_state_e         state_reg;
   bft_state_e         state_next;
   logic [1:0]         op_reg;
   logic [2:0]         mode_reg;
   logic [4:0]         dest_reg;
   logic               limit_req_reg;
   logic [15:0]        mask_reg;
   logic [15:0]        operand_reg;
   logic [15:0]        sw_reg;
   logic [15:0]        pc_reg;
   logic [15:0]        dreg_reg;
   logic [15:0]        r2_reg;
   logic [15:0]        sp_reg;
   logic [MEM_AW-1:0]  mem_addr_reg;
   logic               illegal_reg;
   logic [3:0]         cyc_last_reg;
   logic [1:0]         wrd_last_reg;
   logic [1:0]         acc_cnt_reg;
   logic [3:0]         cnt_reg;
   logic [15:0]        opnd_val_reg;
   logic               ack_reg;
   logic [31:0]        rdata_reg;

   // Bus decode
   wire        bus_req    = i_avs_read | i_avs_write;
   wire        busy       = (state_reg != ST_IDLE);
   wire        ctrl_block = i_avs_write & (i_avs_address == bft_pkg::OFS_CTRL) & busy;
   wire        bus_done   = bus_req & ack_reg & ~ctrl_block;
   wire        wr_take    = i_avs_write & bus_done;
   wire        wr_ctrl    = wr_take & (i_avs_address == bft_pkg::OFS_CTRL);
   wire        wr_mask    = wr_take & (i_avs_address == bft_pkg::OFS_MASK);
   wire        wr_opnd    = wr_take & (i_avs_address == bft_pkg::OFS_OPERAND);
   wire        wr_sw      = wr_take & (i_avs_address == bft_pkg::OFS_STATUS_W);
   wire        wr_pc      = wr_take & (i_avs_address == bft_pkg::OFS_PC);
   wire        wr_dreg    = wr_take & (i_avs_address == bft_pkg::OFS_DREG);
   wire        wr_agu     = wr_take & (i_avs_address == bft_pkg::OFS_AGU);
   wire        wr_maddr   = wr_take & (i_avs_address == bft_pkg::OFS_MEM_ADDR);
   wire        wr_mdata   = wr_take & (i_avs_address == bft_pkg::OFS_MEM_DATA);

   // Incoming instruction fields
   wire [1:0]  new_op     = i_avs_writedata[bft_pkg::CTRL_OP_LSB +: 2];
   wire [2:0]  new_mode   = i_avs_writedata[bft_pkg::CTRL_MODE_LSB +: 3];
   wire [4:0]  new_dest   = i_avs_writedata[bft_pkg::CTRL_DEST_LSB +: 5];
   wire        new_is_tst = (new_op == bft_pkg::OP_TEST_ONES) |
                            (new_op == bft_pkg::OP_TEST_ZEROS);
   wire        new_bad    = (new_op == bft_pkg::OP_RSVD) |
                            (new_is_tst & (new_mode > bft_pkg::AM_LONG)) |
                            (new_is_tst & (new_mode == bft_pkg::AM_REG) &
                             (new_dest == bft_pkg::STACK_REG_CODE));
   wire        start      = wr_ctrl & ~new_bad;

   // Cycle count per mode; indexed and long forms need the extra cycles
   function automatic logic [3:0] test_cycles(input logic [2:0] mode);
      test_cycles = ((mode == bft_pkg::AM_IDX_R2) | (mode == bft_pkg::AM_IDX_SP) |
                     (mode == bft_pkg::AM_LONG)) ? bft_pkg::TEST_CYC_LONG
                                                 : bft_pkg::TEST_CYC_SHORT;
   endfunction

   wire [3:0]  new_cycles = (new_op == bft_pkg::OP_BRANCH)
                            ? 4'(bft_pkg::BRANCH_CYC + WAIT_STATES)
                            : test_cycles(new_mode);
   wire [1:0]  new_words  = (new_op == bft_pkg::OP_BRANCH) ? bft_pkg::BRANCH_WRD :
                            (new_mode == bft_pkg::AM_LONG) ? bft_pkg::TEST_WRD_LONG
                                                           : bft_pkg::TEST_WRD_SHORT;

   // Effective address of a memory destination
   wire [15:0] short_ofs  = {10'h000, operand_reg[5:0]};
   wire [15:0] eff_addr   =
      (mode_reg == bft_pkg::AM_IDX_R2)   ? 16'(r2_reg + short_ofs) :
      (mode_reg == bft_pkg::AM_IDX_SP)   ? 16'(sp_reg - short_ofs) :
      (mode_reg == bft_pkg::AM_SHORT)    ? short_ofs :
      (mode_reg == bft_pkg::AM_IO_SHORT) ? {bft_pkg::IO_PAGE, operand_reg[5:0]} :
                                           operand_reg;
   wire        is_test    = (op_reg != bft_pkg::OP_BRANCH);
   wire        from_reg   = (mode_reg == bft_pkg::AM_REG);
   wire        do_access  = is_test & ((state_reg == ST_ACC1) | (state_reg == ST_ACC2));

   // Operand path: reads only, the write port serves software loads
   assign mem_bus.rd_en   = do_access & ~from_reg;
   assign mem_bus.rd_addr = eff_addr[MEM_AW-1:0];
   assign mem_bus.wr_en   = wr_mdata;
   assign mem_bus.wr_addr = mem_addr_reg;
   assign mem_bus.wr_data = i_avs_writedata[15:0];

   bft_opnd_mem #(.AW(MEM_AW), .DW(16)) u_mem (
      .i_clk    (i_clk),
      .mem_port (mem_bus.mem)
   );

   wire [15:0] dest_val = from_reg ? dreg_reg : mem_bus.rd_data;
   wire        match;

   bft_bit_test #(.W(16)) u_test (
      .i_mask      (mask_reg),
      .i_data      (opnd_val_reg),
      .i_ones_mode (op_reg == bft_pkg::OP_TEST_ONES),
      .o_all_match (match)
   );

   // Branch target from the address after this one-word instruction
   wire [15:0] disp_ext   = {{9{operand_reg[6]}}, operand_reg[6:0]};
   wire [15:0] pc_after   = 16'(pc_reg + {14'h0000, wrd_last_reg});
   wire [15:0] pc_branch  = 16'(pc_after + disp_ext);
   wire        finish     = (state_reg == ST_WAIT) & (cnt_reg == 4'h0);

   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE : state_next = start ? ST_ACC1 : ST_IDLE;
         ST_ACC1 : state_next = ST_ACC2;
         ST_ACC2 : state_next = ST_EVAL;
         ST_EVAL : state_next = ST_WAIT;
         ST_WAIT : state_next = finish ? ST_IDLE : ST_WAIT;
         default : state_next = ST_IDLE;
      endcase
   end

   // Sequencer
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         state_reg   <= ST_IDLE;
         cnt_reg     <= 4'h0;
         acc_cnt_reg <= 2'h0;
      end
      else
      begin
         state_reg <= state_next;
         if (start)
         begin
            cnt_reg     <= 4'(new_cycles - 4'h4);
            acc_cnt_reg <= 2'h0;
         end
         else if (state_reg == ST_WAIT && cnt_reg != 4'h0)
         begin
            cnt_reg <= 4'(cnt_reg - 4'h1);
         end
         if (do_access)
         begin
            acc_cnt_reg <= 2'(acc_cnt_reg + 2'h1);
         end
      end
   end

   // Second access supplies the value that is tested
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         opnd_val_reg <= 16'h0000;
      end
      else if (state_reg == ST_ACC2 || state_reg == ST_EVAL)
      begin
         opnd_val_reg <= dest_val;
      end
   end

   // Instruction latch and software registers
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         op_reg        <= 2'h0;
         mode_reg      <= 3'h0;
         dest_reg      <= 5'h00;
         limit_req_reg <= 1'b0;
         mask_reg      <= 16'h0000;
         operand_reg   <= 16'h0000;
         dreg_reg      <= 16'h0000;
         r2_reg        <= 16'h0000;
         sp_reg        <= 16'h0000;
         mem_addr_reg  <= '0;
         illegal_reg   <= 1'b0;
         cyc_last_reg  <= 4'h0;
         wrd_last_reg  <= 2'h0;
      end
      else
      begin
         if (wr_ctrl)
         begin
            illegal_reg <= new_bad;
         end
         if (start)
         begin
            op_reg        <= new_op;
            mode_reg      <= new_mode;
            dest_reg      <= new_dest;
            limit_req_reg <= i_avs_writedata[bft_pkg::CTRL_LIMIT];
            cyc_last_reg  <= new_cycles;
            wrd_last_reg  <= new_words;
         end
         if (wr_mask)  mask_reg     <= i_avs_writedata[15:0];
         if (wr_opnd)  operand_reg  <= i_avs_writedata[15:0];
         if (wr_dreg)  dreg_reg     <= i_avs_writedata[15:0];
         if (wr_maddr) mem_addr_reg <= i_avs_writedata[MEM_AW-1:0];
         if (wr_agu)
         begin
            r2_reg <= i_avs_writedata[15:0];
            sp_reg <= i_avs_writedata[31:16];
         end
      end
   end

   // Program counter and status word commit at the last cycle
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         pc_reg <= bft_pkg::PC_RESET;
         sw_reg <= bft_pkg::SW_RESET;
      end
      else if (finish)
      begin
         if (is_test)
         begin
            pc_reg                    <= pc_after;
            // Operand is settled through the wait phase, so no extra flop is needed
            sw_reg[bft_pkg::SW_CARRY] <= match;
            if (limit_req_reg)
            begin
               sw_reg[bft_pkg::SW_LIMIT] <= 1'b1;
            end
         end
         else
         begin
            pc_reg <= pc_branch;
         end
      end
      else
      begin
         if (wr_pc) pc_reg <= i_avs_writedata[15:0];
         if (wr_sw) sw_reg <= i_avs_writedata[15:0];
      end
   end

   // Read mux; unmapped offsets read zero
   wire [31:0] state_word = {22'h00_0000, acc_cnt_reg, wrd_last_reg, cyc_last_reg,
                             illegal_reg, busy};
   wire [31:0] rd_mux =
      (i_avs_address == bft_pkg::OFS_CTRL)     ? {21'h00_0000, limit_req_reg, dest_reg,
                                                  mode_reg, op_reg} :
      (i_avs_address == bft_pkg::OFS_MASK)     ? {16'h0000, mask_reg} :
      (i_avs_address == bft_pkg::OFS_OPERAND)  ? {16'h0000, operand_reg} :
      (i_avs_address == bft_pkg::OFS_STATUS_W) ? {16'h0000, sw_reg} :
      (i_avs_address == bft_pkg::OFS_PC)       ? {16'h0000, pc_reg} :
      (i_avs_address == bft_pkg::OFS_STATE)    ? state_word :
      (i_avs_address == bft_pkg::OFS_DREG)     ? {16'h0000, dreg_reg} :
      (i_avs_address == bft_pkg::OFS_AGU)      ? {sp_reg, r2_reg} :
      (i_avs_address == bft_pkg::OFS_MEM_ADDR) ? 32'(mem_addr_reg) :
                                                 32'h0000_0000;

   // One wait cycle per access; a start while busy is held off, not dropped
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         ack_reg   <= 1'b0;
         rdata_reg <= 32'h0000_0000;
      end
      else
      begin
         ack_reg <= bus_req & ~ack_reg;
         if (i_avs_read & ~ack_reg)
         begin
            rdata_reg <= rd_mux;
         end
      end
   end

   assign o_avs_waitrequest = bus_req & ~bus_done;
   assign o_avs_readdata    = rdata_reg;
   assign o_busy            = busy;
   assign o_pc              = pc_reg;
   assign o_status_word     = sw_reg;
endmodule
`default_nettype wire

// ---- hw/bft_mem_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface bft_mem_if #(parameter int AW = 8, parameter int DW = 16);
   logic          rd_en;
   logic [AW-1:0] rd_addr;
   logic [DW-1:0] rd_data;
   logic          wr_en;
   logic [AW-1:0] wr_addr;
   logic [DW-1:0] wr_data;
   modport ctl (output rd_en, rd_addr, wr_en, wr_addr, wr_data, input rd_data);
   modport mem (input rd_en, rd_addr, wr_en, wr_addr, wr_data, output rd_data);
endinterface
`default_nettype wire

// ---- hw/bft_opnd_mem.sv ----
`timescale 1ns/1ps
`default_nettype none
module bft_opnd_mem #(
   parameter int AW = 8,
   parameter int DW = 16
) (
   input  wire logic i_clk,
   bft_mem_if.mem    mem_port
);
   logic [DW-1:0] store [0:(1<<AW)-1];
   logic [DW-1:0] rd_data_reg;

   always_ff @(posedge i_clk)
   begin
      if (mem_port.wr_en)
      begin
         store[mem_port.wr_addr] <= mem_port.wr_data;
      end
      if (mem_port.rd_en)
      begin
         rd_data_reg <= store[mem_port.rd_addr];
      end
   end

   assign mem_port.rd_data = rd_data_reg;
endmodule
`default_nettype wire

// ---- hw/bft_pkg.sv ----
package bft_pkg;
   // Avalon word offsets (byte addresses)
   localparam logic [7:0] OFS_CTRL     = 8'h00;
   localparam logic [7:0] OFS_MASK     = 8'h04;
   localparam logic [7:0] OFS_OPERAND  = 8'h08;
   localparam logic [7:0] OFS_STATUS_W = 8'h0C;
   localparam logic [7:0] OFS_PC       = 8'h10;
   localparam logic [7:0] OFS_STATE    = 8'h14;
   localparam logic [7:0] OFS_DREG     = 8'h18;
   localparam logic [7:0] OFS_AGU      = 8'h1C;
   localparam logic [7:0] OFS_MEM_ADDR = 8'h20;
   localparam logic [7:0] OFS_MEM_DATA = 8'h24;
   // Control word fields
   localparam int CTRL_OP_LSB   = 0;
   localparam int CTRL_MODE_LSB = 2;
   localparam int CTRL_DEST_LSB = 5;
   localparam int CTRL_LIMIT    = 10;
   // Status word flag positions
   localparam int SW_CARRY = 0;
   localparam int SW_LIMIT = 6;
   // State register fields
   localparam int ST_BUSY    = 0;
   localparam int ST_ILLEGAL = 1;
   localparam int ST_CYC_LSB = 2;
   localparam int ST_WRD_LSB = 6;
   localparam int ST_ACC_LSB = 8;
   // Reset values
   localparam logic [15:0] SW_RESET = 16'h0000;
   localparam logic [15:0] PC_RESET = 16'h0000;
   // Operand encodings
   localparam logic [4:0]  STACK_REG_CODE = 5'h1F;
   localparam logic [9:0]  IO_PAGE    = 10'h3FF;
   localparam logic [5:0]  SHORT_ZERO = 6'h00;
   // Cycle and word counts
   localparam logic [3:0] TEST_CYC_SHORT = 4'h4;
   localparam logic [3:0] TEST_CYC_LONG  = 4'h6;
   localparam logic [3:0] BRANCH_CYC     = 4'h6;
   localparam logic [1:0] TEST_WRD_SHORT = 2'h2;
   localparam logic [1:0] TEST_WRD_LONG  = 2'h3;
   localparam logic [1:0] BRANCH_WRD     = 2'h1;
   typedef enum logic [1:0] {
      OP_TEST_ONES, OP_TEST_ZEROS, OP_BRANCH, OP_RSVD
   } bft_op_e;
   typedef enum logic [2:0] {
      AM_REG, AM_IDX_R2, AM_IDX_SP, AM_SHORT, AM_IO_SHORT, AM_LONG, AM_RSVD6, AM_RSVD7
   } bft_mode_e;
endpackage

// ---- tb/bft_core_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
module bft_core_asserts #(
   parameter int         MEM_AW      = 8,
   parameter logic [3:0] WAIT_STATES = 4'h0
) (
   input wire logic        i_clk,
   input wire logic        i_sys_rst,
   input wire logic [7:0]  i_avs_address,
   input wire logic        i_avs_read,
   input wire logic        i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [31:0] o_avs_readdata,
   input wire logic        o_avs_waitrequest,
   input wire logic        o_busy,
   input wire logic [15:0] o_pc,
   input wire logic [15:0] o_status_word
);
   logic [10:0] ctl_reg;
   logic [15:0] mask_reg;
   logic [15:0] opnd_reg;
   logic [15:0] pc0_reg;
   logic [4:0]  cnt_reg;
   // Captures only idle-time writes; a CTRL write stalled by busy completes while idle, so it is captured too
   wire         wr_ok   = i_avs_write && !o_avs_waitrequest && !o_busy;
   wire         is_br   = ctl_reg[1:0] == bft_pkg::OP_BRANCH;
   wire         is_tst  = ctl_reg[1] == 1'b0;
   wire         long_am = ctl_reg[4:2] inside {3'h1, 3'h2, 3'h5};
   wire [15:0]  br_pc   = pc0_reg + 16'h0001 + {{9{opnd_reg[6]}}, opnd_reg[6:0]};
   wire [15:0]  ts_pc   = pc0_reg + ((ctl_reg[4:2] == 3'h5) ? 16'h0003 : 16'h0002);
   wire [4:0]   br_cyc  = 5'h06 + {1'b0, WAIT_STATES};

   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         ctl_reg  <= 11'h000;
         mask_reg <= 16'h0000;
         opnd_reg <= 16'h0000;
         pc0_reg  <= 16'h0000;
         cnt_reg  <= 5'h00;
      end
      else
      begin
         cnt_reg <= o_busy ? cnt_reg + 5'h01 : 5'h00;
         if (wr_ok && i_avs_address == bft_pkg::OFS_CTRL)
         begin
            ctl_reg <= i_avs_writedata[10:0];
            pc0_reg <= o_pc;
         end
         if (wr_ok && i_avs_address == bft_pkg::OFS_MASK)
            mask_reg <= i_avs_writedata[15:0];
         if (wr_ok && i_avs_address == bft_pkg::OFS_OPERAND)
            opnd_reg <= i_avs_writedata[15:0];
      end
   end

   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_sys_rst);

   property p_rd_wait;
      $rose(i_avs_read) |-> o_avs_waitrequest ##1 !o_avs_waitrequest;
   endproperty
   a_rd_wait: assert property (p_rd_wait) else $error("read answer not after one wait");
   property p_min_busy;
      $rose(o_busy) |-> o_busy [*4];
   endproperty
   a_min_busy: assert property (p_min_busy) else $error("busy shorter than four");
   property p_test_cyc;
      $fell(o_busy) && is_tst |-> cnt_reg == (long_am ? 5'h06 : 5'h04);
   endproperty
   a_test_cyc: assert property (p_test_cyc) else $error("test cycle count wrong");
   property p_test_pc;
      $fell(o_busy) && is_tst |-> o_pc == ts_pc;
   endproperty
   a_test_pc: assert property (p_test_pc) else $error("test word count wrong");
   property p_br_cyc;
      $fell(o_busy) && is_br |-> cnt_reg == br_cyc;
   endproperty
   a_br_cyc: assert property (p_br_cyc) else $error("branch cycle count wrong");
   property p_br_pc;
      $fell(o_busy) && is_br |-> o_pc == br_pc;
   endproperty
   a_br_pc: assert property (p_br_pc) else $error("branch target wrong");
   property p_br_flags;
      $fell(o_busy) && is_br |-> $stable(o_status_word);
   endproperty
   a_br_flags: assert property (p_br_flags) else $error("branch changed flags");
   property p_empty_mask;
      $fell(o_busy) && is_tst && mask_reg == 16'h0000 |-> o_status_word[bft_pkg::SW_CARRY];
   endproperty
   a_empty_mask: assert property (p_empty_mask) else $error("empty mask carry clear");
   property p_limit;
      $fell(o_busy) && is_tst && ctl_reg[10] |-> o_status_word[bft_pkg::SW_LIMIT];
   endproperty
   a_limit: assert property (p_limit) else $error("limit flag not set");

   c_branch: cover property ($fell(o_busy) && is_br);
   c_long: cover property ($fell(o_busy) && is_tst && long_am);
   c_empty: cover property ($fell(o_busy) && is_tst && mask_reg == 16'h0000);
endmodule

bind bft_core bft_core_asserts #(.MEM_AW(MEM_AW), .WAIT_STATES(WAIT_STATES)) u_chk (
   .i_clk, .i_sys_rst, .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata,
   .o_avs_readdata, .o_avs_waitrequest, .o_busy, .o_pc, .o_status_word
);
`default_nettype wire

// ---- tb/bitfield_test_and_short_branch_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module bitfield_test_and_short_branch_bench;
   logic        clk;
   logic        rst;
   logic [7:0]  adr;
   logic        rd;
   logic        wr;
   logic [31:0] wdat;
   logic [31:0] rdat;
   logic        wreq;
   logic        busy;
   logic [15:0] pc;
   logic [15:0] sw;
   logic [31:0] q;
   int          err_total;
   int          n_tests;
   logic [6:0]  disp [4] = '{7'h02, 7'h40, 7'h3F, 7'h7F};

   bft_core #(.MEM_AW(8), .WAIT_STATES(4'h2)) uut (
      .i_clk             (clk),
      .i_sys_rst         (rst),
      .i_avs_address     (adr),
      .i_avs_read        (rd),
      .i_avs_write       (wr),
      .i_avs_writedata   (wdat),
      .o_avs_readdata    (rdat),
      .o_avs_waitrequest (wreq),
      .o_busy            (busy),
      .o_pc              (pc),
      .o_status_word     (sw)
   );

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         err_total++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // A CTRL write during an instruction stalls; the wait ends once the instruction finishes
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      adr  <= a;
      wr   <= w;
      rd   <= !w;
      wdat <= d;
      do
      begin
         @(posedge clk);
      end
      while (wreq !== 1'b0);
      q = rdat;
      wr <= 1'b0;
      rd <= 1'b0;
      @(posedge clk);
   endtask

   task automatic wrr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      bus(1'b0, a, 32'h0000_0000);
      check(q & m, e);
   endtask

   function automatic logic [31:0] cw(input logic [1:0] op, input logic [2:0] m,
                                      input logic [4:0] d, input logic l);
      return {21'h00_0000, l, d, m, op};
   endfunction

   task automatic run(input logic [31:0] c);
      wrr(bft_pkg::OFS_CTRL, c);
      while (busy === 1'b1)
      begin
         @(posedge clk);
      end
   endtask

   task automatic tcase(input logic [1:0] op, input logic [2:0] m, input logic [15:0] o,
                        input logic [7:0] ma, input logic [15:0] dat, input logic [15:0] mk,
                        input logic lim, input logic c);
      logic [3:0] cyc;
      logic [1:0] wd;
      cyc = (m inside {3'h1, 3'h2, 3'h5}) ? 4'h6 : 4'h4;
      wd = (m == 3'h5) ? 2'h3 : 2'h2;
      wrr(bft_pkg::OFS_MEM_ADDR, {24'h00_0000, ma});
      wrr(bft_pkg::OFS_MEM_DATA, {16'h0000, dat});
      wrr(bft_pkg::OFS_DREG, {16'h0000, dat});
      wrr(bft_pkg::OFS_STATUS_W, 32'h0000_0000);
      wrr(bft_pkg::OFS_PC, 32'h0000_0010);
      wrr(bft_pkg::OFS_MASK, {16'h0000, mk});
      wrr(bft_pkg::OFS_OPERAND, {16'h0000, o});
      run(cw(op, m, 5'h02, lim));
      check({16'h0000, sw}, {16'h0000, 9'h000, lim, 5'h00, c});
      check({16'h0000, pc}, 32'h0000_0010 + wd);
      rdc(bft_pkg::OFS_STATE, 32'h0000_03FF, {22'h00_0000, 2'h2, wd, cyc, 2'h0});
      rdc(bft_pkg::OFS_DREG, 32'h0000_FFFF, {16'h0000, dat});
      $display("bit test case done at %0t", $time);
   endtask

   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   initial
   begin
      repeat (20000) @(posedge clk);
      err_total++;
      stop_test;
   end

   initial
   begin
      err_total = 0;
      n_tests = 0;
      rst = 1'b1;
      adr = 8'h00;
      rd = 1'b0;
      wr = 1'b0;
      wdat = 32'h0000_0000;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      check({16'h0000, sw}, 32'h0000_0000);
      rdc(bft_pkg::OFS_PC, 32'h0000_FFFF, 32'h0000_0000);
      rdc(8'h28, 32'hFFFF_FFFF, 32'h0000_0000);
      rdc(bft_pkg::OFS_MEM_DATA, 32'hFFFF_FFFF, 32'h0000_0000);
      $display("reset and map test done at %0t", $time);
      // Decoy words sit where an unmasked short address would land
      wrr(bft_pkg::OFS_AGU, 32'h0000_0000);
      wrr(bft_pkg::OFS_MEM_ADDR, 32'h0000_0065);
      wrr(bft_pkg::OFS_MEM_DATA, 32'h0000_0000);
      wrr(bft_pkg::OFS_MEM_ADDR, 32'h0000_0022);
      wrr(bft_pkg::OFS_MEM_DATA, 32'h0000_FFFF);
      tcase(2'h0, 3'h0, 16'h0000, 8'h00, 16'h0FF0, 16'h0310, 1'b0, 1'b1);
      tcase(2'h0, 3'h0, 16'h0000, 8'h00, 16'h0FF0, 16'h0311, 1'b0, 1'b0);
      tcase(2'h0, 3'h0, 16'h0000, 8'h00, 16'h7FFF, 16'h8000, 1'b0, 1'b0);
      tcase(2'h1, 3'h0, 16'h0000, 8'h00, 16'h18EC, 16'h0310, 1'b0, 1'b1);
      tcase(2'h1, 3'h0, 16'h0000, 8'h00, 16'h18EC, 16'h0318, 1'b0, 1'b0);
      tcase(2'h0, 3'h0, 16'h0000, 8'h00, 16'h0000, 16'h0000, 1'b1, 1'b1);
      tcase(2'h1, 3'h0, 16'h0000, 8'h00, 16'hFFFF, 16'h0000, 1'b0, 1'b1);
      tcase(2'h0, 3'h3, 16'h0065, 8'h25, 16'h0FF0, 16'h0310, 1'b0, 1'b1);
      tcase(2'h1, 3'h4, 16'h0022, 8'hE2, 16'h18EC, 16'h0310, 1'b0, 1'b1);
      tcase(2'h0, 3'h1, 16'h0000, 8'h00, 16'h0000, 16'h0000, 1'b0, 1'b1);
      tcase(2'h1, 3'h2, 16'h0000, 8'h00, 16'h0000, 16'h0000, 1'b1, 1'b1);
      tcase(2'h1, 3'h5, 16'h0040, 8'h40, 16'h0000, 16'hFFFF, 1'b0, 1'b1);
      wrr(bft_pkg::OFS_PC, 32'h0000_0010);
      run(cw(2'h0, 3'h0, bft_pkg::STACK_REG_CODE, 1'b0));
      check({31'h0000_0000, busy}, 32'h0000_0000);
      check({16'h0000, pc}, 32'h0000_0010);
      rdc(bft_pkg::OFS_STATE, 32'h0000_0003, 32'h0000_0002);
      run(cw(2'h0, 3'h0, 5'h1E, 1'b0));
      check({16'h0000, pc}, 32'h0000_0012);
      run(cw(2'h1, 3'h6, 5'h02, 1'b0));
      rdc(bft_pkg::OFS_STATE, 32'h0000_0003, 32'h0000_0002);
      run(cw(2'h3, 3'h0, 5'h02, 1'b0));
      rdc(bft_pkg::OFS_STATE, 32'h0000_0003, 32'h0000_0002);
      check({16'h0000, pc}, 32'h0000_0012);
      $display("stack register test done at %0t", $time);
      for (int i = 0; i < 4; i++)
      begin
         // Limit bit starts clear when the branch carries a limit request
         wrr(bft_pkg::OFS_STATUS_W, {25'h000_0000, ~i[0], 5'h00, 1'b1});
         wrr(bft_pkg::OFS_PC, 32'h0000_0100);
         wrr(bft_pkg::OFS_OPERAND, {24'h00_0000, 1'b1, disp[i]});
         run(cw(2'h2, 3'h0, 5'h00, i[0]));
         check({16'h0000, pc}, 32'h0000_0101 + {{25{disp[i][6]}}, disp[i]});
         check({16'h0000, sw}, {25'h000_0000, ~i[0], 5'h00, 1'b1});
         rdc(bft_pkg::OFS_STATE, 32'h0000_00FF, 32'h0000_0060);
         $display("branch case done at %0t", $time);
      end
      stop_test;
   end
endmodule
`default_nettype wire
